//--- rtl/flash_lock_and_calib_load.sv
// lock-bit protection for flash/EEPROM plus factory calibration load.
// assumes cpu, programming interface, nvm and signature row share sys_clk;
// lock_nv holds the stored lock word, sig_row the factory bytes.
`timescale 1ns/1ns
`default_nettype none

module flash_lock_and_calib_load
  import lock_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // nonvolatile lock word and signature row
  input  wire logic [LOCK_W-1:0] lock_nv,
  input  wire sig_row_t          sig_row,
  output logic      [LOCK_W-1:0] lock_word,
  // calibration registers of the oscillators
  output cal_t                   cal,
  output logic                   ready,
  // cpu program-memory accesses
  input  wire cpu_req_t          cpu,
  output cpu_ans_t               cpu_ans,
  // external programming interface
  input  wire ext_req_t          ext,
  output ext_ans_t               ext_ans,
  // avalon-mm slave
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest
);

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_CAL  = 2'b01,
    ST_RUN  = 2'b11
  } st_t;

  // tighten only: a zero bit survives until chip erase
  function automatic logic [LOCK_W-1:0] tighten(
    input logic [LOCK_W-1:0] cur,
    input logic [LOCK_W-1:0] wr
  );
    tighten = cur & wr;
  endfunction

  function automatic logic [1:0] field(
    input logic [LOCK_W-1:0] w,
    input int                lsb
  );
    field = w[lsb+:2];
  endfunction

  st_t               st_q;
  st_t               st_d;
  logic [LOCK_W-1:0] lock_q;
  logic [LOCK_W-1:0] lock_d;
  logic [LOCK_W-1:0] sw_tight;
  cal_t              cal_q;
  cal_t              cal_d;
  logic              ack_q;
  logic              ack_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;

  logic [1:0]  app_lk;
  logic [1:0]  tbl_lk;
  logic [1:0]  ext_lk;
  logic        req;
  logic        sw_lock_wr;
  logic [3:0]  idx;

  assign app_lk = field(lock_q, APP_LSB);
  assign tbl_lk = field(lock_q, TBL_LSB);
  assign ext_lk = field(lock_q, EXT_LSB);
  assign idx    = avs_address[5:2];
  assign req    = avs_read | avs_write;
  assign sw_tight = tighten(lock_q, avs_writedata[LOCK_W-1:0]);

  // bus held off until the calibration load is done
  assign avs_waitrequest = req & (~ack_q | (st_q != ST_RUN));
  assign sw_lock_wr = avs_write & ack_q & (st_q == ST_RUN)
                    & (idx == IDX_LOCK) & avs_byteenable[0];

  // startup and lock storage
  always_comb begin
    st_d   = st_q;
    lock_d = lock_q;
    cal_d  = cal_q;
    unique case (st_q)
      ST_LOAD: begin
        lock_d = lock_nv;
        st_d   = ST_CAL;
      end
      ST_CAL: begin
        cal_d.loop2m_b  = sig_row.osc2m_cal_b_factory;  // RULE17
        cal_d.loop2m_a  = sig_row.osc2m_cal_a_factory;  // RULE18
        cal_d.osc32k    = sig_row.osc32k_cal_factory;   // RULE19
        cal_d.loop32m_b = sig_row.osc32m_cal_b_factory; // RULE20
        st_d            = ST_RUN;
      end
      ST_RUN: begin
        // software may tighten only the application fields
        if (sw_lock_wr) begin
          lock_d[APP_LSB+:2] = sw_tight[APP_LSB+:2]; // RULE1 RULE22
          lock_d[TBL_LSB+:2] = sw_tight[TBL_LSB+:2]; // RULE6
        end
        // only the programming interface touches the external field
        if (ext.lock_we && ext_ans.lock_write_ok) begin
          lock_d = tighten(lock_d, ext.lock_wdata); // RULE9
        end
        // erase wins over any write in the same cycle
        if (ext.chip_erase) begin
          lock_d = LOCK_UNLOCKED; // RULE2 RULE10
        end
      end
      default: st_d = ST_LOAD;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q   <= ST_LOAD;
      lock_q <= LOCK_UNLOCKED;
      cal_q  <= '{CAL_RESET, CAL_RESET, CAL_RESET, CAL_RESET};
    end else if (ce) begin
      st_q   <= st_d;
      lock_q <= lock_d;
      cal_q  <= cal_d;
    end
  end

  assign lock_word = lock_q;
  assign cal       = cal_q;
  assign ready     = (st_q == ST_RUN);

  // cpu side checks; the external field is deliberately ignored here
  always_comb begin
    cpu_ans = '{store_ok: 1'b1, load_ok: 1'b1, irq_off: 1'b0}; // RULE12
    if (cpu.self_program_store) begin
      if (cpu.target == SEC_APP && !app_lk[0])
        cpu_ans.store_ok = 1'b0; // RULE3
      if (cpu.target == SEC_TABLE && !tbl_lk[0])
        cpu_ans.store_ok = 1'b0; // RULE7
    end
    if (cpu.program_memory_load && cpu.exec_in_boot) begin
      if (cpu.target == SEC_APP && !app_lk[1])
        cpu_ans.load_ok = 1'b0; // RULE4
      if (cpu.target == SEC_TABLE && !tbl_lk[1])
        cpu_ans.load_ok = 1'b0; // RULE8
    end
    // read-locked fields are the ones with bit 1 low
    if (cpu.ivec_in_boot && !cpu.exec_in_boot
        && (!app_lk[1] || !tbl_lk[1]))
      cpu_ans.irq_off = 1'b1; // RULE5
  end

  // programming interface checks
  always_comb begin
    ext_ans = '1; // RULE13
    if (ext_lk != UNLOCKED_PROG_SETTING) begin
      ext_ans.test_interface_ok   = 1'b0; // RULE11
      ext_ans.on_chip_debugger_ok = 1'b0; // RULE11
      ext_ans.mem_prog_ok         = 1'b0; // RULE14 RULE15
      ext_ans.fuse_write_ok       = 1'b0; // RULE14 RULE15
    end
    if (ext_lk == READ_WRITE_LOCKED_SETTING) begin
      ext_ans.mem_read_ok   = 1'b0; // RULE15
      ext_ans.lock_read_ok  = 1'b0; // RULE15
      ext_ans.lock_write_ok = 1'b0; // RULE15
    end
    // lock field 01 is undefined; treated as fully read-write locked
    if (ext_lk == READ_LOCKED_SETTING) begin
      ext_ans.mem_read_ok   = 1'b0;
      ext_ans.lock_read_ok  = 1'b0;
      ext_ans.lock_write_ok = 1'b0;
    end
  end

  // bus slave: one wait cycle, data from a flop
  always_comb begin
    ack_d   = req & ~ack_q & (st_q == ST_RUN);
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      unique case (idx)
        IDX_OSC2M_B:  rdata_d = {24'h00_0000, sig_row.osc2m_cal_b_factory};
        IDX_OSC2M_A:  rdata_d = {24'h00_0000, sig_row.osc2m_cal_a_factory};
        IDX_OSC32K:   rdata_d = {24'h00_0000, sig_row.osc32k_cal_factory};
        IDX_OSC32M_B: rdata_d = {24'h00_0000, sig_row.osc32m_cal_b_factory};
        IDX_LOCK:     rdata_d = {26'h000_0000, lock_q};
        IDX_STATUS:   rdata_d = {31'h0000_0000, ready};
        default:      rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // factory bytes are read-only: writes to them are dropped (RULE21)

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence load_seq;
    st_q == ST_LOAD ##1 st_q == ST_CAL;
  endsequence

  sequence cal_done_seq;
    ##1 (cal_q.loop2m_b == $past(sig_row.osc2m_cal_b_factory)
         && cal_q.loop2m_a == $past(sig_row.osc2m_cal_a_factory));
  endsequence

  app_no_relax_a: assert property ( // RULE1
    ce && st_q == ST_RUN && !ext.chip_erase
    |=> (field(lock_q, APP_LSB) & ~$past(app_lk)) == 2'h0)
    else $error("application lock relaxed without erase");

  erase_unlock_a: assert property ( // RULE2
    ce && st_q == ST_RUN && ext.chip_erase |=> lock_q == LOCK_UNLOCKED)
    else $error("chip erase did not unlock");

  app_store_block_a: assert property ( // RULE3
    cpu.self_program_store && cpu.target == SEC_APP && !app_lk[0]
    |-> !cpu_ans.store_ok)
    else $error("store into write-locked application");

  app_load_block_a: assert property ( // RULE4
    cpu.program_memory_load && cpu.exec_in_boot
    && cpu.target == SEC_APP && !app_lk[1] |-> !cpu_ans.load_ok)
    else $error("boot load from read-locked application");

  irq_mask_a: assert property ( // RULE5
    cpu.ivec_in_boot && !cpu.exec_in_boot && !app_lk[1]
    |-> cpu_ans.irq_off)
    else $error("interrupts not masked in application");

  tbl_no_relax_a: assert property ( // RULE6
    ce && st_q == ST_RUN && !ext.chip_erase
    |=> (field(lock_q, TBL_LSB) & ~$past(tbl_lk)) == 2'h0)
    else $error("table lock relaxed without erase");

  tbl_store_block_a: assert property ( // RULE7
    cpu.self_program_store && cpu.target == SEC_TABLE && !tbl_lk[0]
    |-> !cpu_ans.store_ok)
    else $error("store into write-locked table");

  tbl_load_block_a: assert property ( // RULE8
    cpu.program_memory_load && cpu.exec_in_boot
    && cpu.target == SEC_TABLE && !tbl_lk[1] |-> !cpu_ans.load_ok)
    else $error("boot load from read-locked table");

  ext_sw_write_a: assert property ( // RULE9
    ce && sw_lock_wr && !ext.lock_we && !ext.chip_erase
    |=> lock_q[EXT_LSB+:2] == $past(ext_lk))
    else $error("software changed external lock field");

  debug_block_a: assert property ( // RULE11
    ext_lk != UNLOCKED_PROG_SETTING
    |-> !ext_ans.test_interface_ok && !ext_ans.on_chip_debugger_ok)
    else $error("debug access with external lock set");

  cpu_ignores_ext_a: assert property ( // RULE12
    !cpu.self_program_store && !cpu.program_memory_load
    |-> cpu_ans.store_ok && cpu_ans.load_ok)
    else $error("idle cpu access refused");

  ext_free_a: assert property ( // RULE13
    ext_lk == UNLOCKED_PROG_SETTING |-> ext_ans == '1)
    else $error("unlocked programming interface restricted");

  ext_write_locked_setting_a: assert property ( // RULE14
    ext_lk == WRITE_LOCKED_SETTING
    |-> !ext_ans.mem_prog_ok && !ext_ans.fuse_write_ok
        && ext_ans.mem_read_ok)
    else $error("write lock answers wrong");

  ext_read_write_locked_setting_a: assert property ( // RULE15
    ext_lk == READ_WRITE_LOCKED_SETTING
    |-> !ext_ans.mem_read_ok && !ext_ans.lock_read_ok
        && !ext_ans.lock_write_ok && !ext_ans.mem_prog_ok)
    else $error("read-write lock answers wrong");

  cal_2m_load_a: assert property ( // RULE17
    ce && st_q == ST_CAL |-> cal_done_seq)
    else $error("2MHz calibration not loaded");

  cal_startup_a: assert property ( // RULE18
    load_seq |=> st_q == ST_RUN || !$past(ce))
    else $error("startup sequence stalled");

  cal_32k_load_a: assert property ( // RULE19
    ce && st_q == ST_CAL
    |=> cal_q.osc32k == $past(sig_row.osc32k_cal_factory))
    else $error("32kHz calibration not loaded");

  cal_32m_load_a: assert property ( // RULE20
    ce && st_q == ST_CAL
    |=> cal_q.loop32m_b == $past(sig_row.osc32m_cal_b_factory))
    else $error("32MHz calibration not loaded");

  cal_hold_a: assert property ( // RULE21
    st_q == ST_RUN |=> $stable(cal_q))
    else $error("calibration changed after load");

  lock_and_a: assert property ( // RULE22
    ce && sw_lock_wr && !ext.lock_we && !ext.chip_erase
    |=> lock_q[APP_LSB+:2] == ($past(app_lk)
        & $past(avs_writedata[APP_LSB+:2])))
    else $error("lock write is not an AND");

  bus_answer_a: assert property (
    st_q == ST_RUN && req && !ack_q && ce |=> !avs_waitrequest || !req)
    else $error("bus answer late");

  ext_no_relax_a: assert property ( // RULE10
    ce && st_q == ST_RUN && !ext.chip_erase
    |=> (ext_lk & ~$past(ext_lk)) == 2'h0)
    else $error("external lock relaxed without erase");

  ext_refuse_a: assert property ( // RULE15
    ce && st_q == ST_RUN && ext_lk == READ_WRITE_LOCKED_SETTING
    && !ext.chip_erase && !sw_lock_wr |=> lock_q == $past(lock_q))
    else $error("locked external field accepted a write");

  irq_tbl_mask_a: assert property ( // RULE5
    cpu.ivec_in_boot && !cpu.exec_in_boot && !tbl_lk[1]
    |-> cpu_ans.irq_off)
    else $error("interrupts not masked for table lock");

  app_store_free_a: assert property ( // RULE3
    cpu.self_program_store && cpu.target == SEC_APP && app_lk[0]
    |-> cpu_ans.store_ok)
    else $error("store into open application refused");

  tbl_store_free_a: assert property ( // RULE7
    cpu.self_program_store && cpu.target == SEC_TABLE && tbl_lk[0]
    |-> cpu_ans.store_ok)
    else $error("store into open table refused");

  app_load_free_a: assert property ( // RULE4
    cpu.program_memory_load && cpu.exec_in_boot
    && cpu.target == SEC_APP && app_lk[1] |-> cpu_ans.load_ok)
    else $error("boot load from open application refused");

  nv_load_a: assert property (
    ce && !rst && st_q == ST_LOAD |=> lock_q == $past(lock_nv))
    else $error("stored lock word not loaded");

  ce_freeze_a: assert property (
    !ce |=> $stable(lock_q) && $stable(st_q) && $stable(ack_q))
    else $error("state moved with clock enable low");

  sequence rd_lock_seq;
    ce && st_q == ST_RUN && avs_read && !ack_q && idx == IDX_LOCK;
  endsequence

  lock_readback_a: assert property (
    rd_lock_seq |=> avs_readdata == {26'h000_0000, $past(lock_q)})
    else $error("lock word read back wrong");

endmodule

`default_nettype wire

//--- rtl/lock_pkg.sv
// Function
// (RULE1) application section lock field accepts only stricter or unchanged values
// (RULE2) application section lock returns to unlocked only on chip erase
// (RULE3) application lock 10 or 00 blocks self-program stores into application
// (RULE4) application lock 01 or 00 refuses boot-side loads from application
// (RULE5) read-locked application fields with boot vectors mask interrupts in app
// (RULE6) application table lock only tightens, cleared only by chip erase
// (RULE7) table lock 10 or 00 blocks self-program stores into table section
// (RULE8) table lock 01 or 00 refuses boot-side loads from table section
// (RULE9) external programming lock field writable only by programming interface
// (RULE10) external programming lock unlocked again only by chip erase
// (RULE11) any zero external lock bit blocks test interface and debugger
// (RULE12) external programming lock never restricts on-chip software accesses
// (RULE13) external lock 11 applies no programming interface locks
// (RULE14) external lock 10 blocks flash/EEPROM programming and fuse writes
// (RULE15) external lock 00 blocks programming, read-back, lock and fuse access
// (RULE16) programmer sets fuses and boot locks before external lock field
// (RULE17) reset copies signature byte 0x00 into 2MHz loop calibration B
// (RULE18) reset copies signature byte 0x01 into 2MHz loop calibration A
// (RULE19) reset copies low-frequency oscillator factory byte into its calibration
// (RULE20) reset copies signature byte 0x03 into 32MHz loop calibration B
// (RULE21) factory calibration bytes are eight-bit, read-only, production fixed
// (RULE22) lock writes store AND of current and written value
//
// shared constants and carriers for the flash lock and calibration block.
// assumes one 25 MHz clock; nvm and signature row sit on the same clock.
package lock_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_OSC2M_B  = 4'h0;
  localparam logic [3:0] IDX_OSC2M_A  = 4'h1;
  localparam logic [3:0] IDX_OSC32K   = 4'h2;
  localparam logic [3:0] IDX_OSC32M_B = 4'h3;
  localparam logic [3:0] IDX_LOCK     = 4'h8;
  localparam logic [3:0] IDX_STATUS   = 4'h9;

  // lock word layout
  localparam int LOCK_W   = 6;
  localparam int APP_LSB  = 4;
  localparam int TBL_LSB  = 2;
  localparam int EXT_LSB  = 0;
  localparam logic [5:0] LOCK_UNLOCKED = 6'h3F;
  localparam logic [1:0] UNLOCKED_SETTING          = 2'h3;
  localparam logic [1:0] WRITE_LOCKED_SETTING      = 2'h2;
  localparam logic [1:0] READ_LOCKED_SETTING       = 2'h1;
  localparam logic [1:0] READ_WRITE_LOCKED_SETTING = 2'h0;
  localparam logic [1:0] UNLOCKED_PROG_SETTING     = 2'h3;

  // status word: bit 0 calibration loaded
  localparam int STAT_READY = 0;
  localparam logic [7:0] CAL_RESET = 8'h00;

  typedef enum logic [1:0] {
    SEC_APP   = 2'h0,
    SEC_TABLE = 2'h1,
    SEC_BOOT  = 2'h2
  } sec_t;

  typedef struct packed {
    logic [7:0] osc2m_cal_b_factory;
    logic [7:0] osc2m_cal_a_factory;
    logic [7:0] osc32k_cal_factory;
    logic [7:0] osc32m_cal_b_factory;
  } sig_row_t;

  typedef struct packed {
    logic [7:0] loop2m_b;
    logic [7:0] loop2m_a;
    logic [7:0] osc32k;
    logic [7:0] loop32m_b;
  } cal_t;

  typedef struct packed {
    logic self_program_store;
    logic program_memory_load;
    logic exec_in_boot;
    logic ivec_in_boot;
    sec_t target;
  } cpu_req_t;

  typedef struct packed {
    logic store_ok;
    logic load_ok;
    logic irq_off;
  } cpu_ans_t;

  typedef struct packed {
    logic       chip_erase;
    logic       lock_we;
    logic [5:0] lock_wdata;
  } ext_req_t;

  typedef struct packed {
    logic test_interface_ok;
    logic on_chip_debugger_ok;
    logic mem_prog_ok;
    logic mem_read_ok;
    logic fuse_write_ok;
    logic lock_read_ok;
    logic lock_write_ok;
  } ext_ans_t;

endpackage

//--- verification/prog_model.sv
// external programming interface model: pulses lock writes and erases.
// assumes the block takes one-cycle ext pulses on the rising edge.
`timescale 1ns/1ns
`default_nettype none

module prog_model
  import lock_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // request toward the block
  output ext_req_t  ext
);
  initial ext = '0;

  task automatic pulse(input logic e, input logic w, input logic [5:0] d);
    @(posedge sys_clk);
    ext <= '{chip_erase: e, lock_we: w, lock_wdata: d};
    @(posedge sys_clk);
    ext <= '0;
  endtask

  // boot-side fields go first; an external field at 01 or 00 would refuse them
  task automatic prog_fields(input logic [3:0] at, input logic [1:0] xf);
    pulse(1'b0, 1'b1, {at, 2'h3});
    pulse(1'b0, 1'b1, {4'hF, xf});
  endtask
endmodule

`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the flash lock and calibration load block.
// assumes prog_model drives the programming side; one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module tb
  import lock_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic        ce;
  cpu_req_t    cpu;
  cpu_ans_t    cpu_ans;
  ext_req_t    ext;
  ext_ans_t    ext_ans;
  logic [5:0]  lock_word;
  cal_t        cal;
  logic        ready;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          errors;
  int          total_checks;

  flash_lock_and_calib_load flash_lock_and_calib_load_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .lock_nv(6'h3F),
    .sig_row(32'h5AC3_963C), .lock_word(lock_word), .cal(cal),
    .ready(ready), .cpu(cpu), .cpu_ans(cpu_ans), .ext(ext),
    .ext_ans(ext_ans), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  prog_model prog_model_inst (.sys_clk(sys_clk), .ext(ext));

  task automatic wrap_up();
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // master holds the request until it sees waitrequest low at an edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0)
      errors++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask

  task automatic lk(input logic [5:0] e);
    @(negedge sys_clk);
    chk(32'(lock_word), 32'(e));
  endtask

  function automatic cpu_req_t mk(logic s, logic l, logic e, logic v,
                                  sec_t t);
    return '{s, l, e, v, t};
  endfunction

  task automatic cpu_chk(input cpu_req_t r, input int i, input logic e);
    @(posedge sys_clk);
    cpu <= r;
    @(negedge sys_clk);
    chk({31'h0, cpu_ans[i]}, {31'h0, e});
  endtask

  task automatic t_reset();
    int n;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(32'(lock_word), 32'h3F);
    chk({31'h0, ready}, 32'h0);
    @(posedge sys_clk);
    rst <= 1'b0;
    for (n = 0; n < 10 && ready !== 1'b1; n++)
      @(negedge sys_clk);
    chk({31'h0, ready}, 32'h1);
  endtask

  task automatic t_calib();
    chk(32'(cal.loop2m_b), 32'h5A);
    chk(32'(cal.loop2m_a), 32'hC3);
    chk(32'(cal.osc32k), 32'h96);
    chk(32'(cal.loop32m_b), 32'h3C);
    rd_chk(6'h00, 32'h5A);
    rd_chk(6'h04, 32'hC3);
    rd_chk(6'h08, 32'h96);
    rd_chk(6'h0C, 32'h3C);
    wr(6'h00, 32'hFF);
    rd_chk(6'h00, 32'h5A);
    rd_chk(6'h24, 32'h1);
    rd_chk(6'h3C, 32'h0);
  endtask

  task automatic t_soft_lock();
    wr(6'h20, 32'h2B);
    lk(6'h2B);
    wr(6'h20, 32'h3F);
    lk(6'h2B);
    rd_chk(6'h20, 32'h2B);
    cpu_chk(mk(1, 0, 0, 0, SEC_APP), 2, 1'b0);
    cpu_chk(mk(1, 0, 0, 0, SEC_TABLE), 2, 1'b0);
    cpu_chk(mk(1, 0, 0, 0, SEC_BOOT), 2, 1'b1);
    cpu_chk(mk(0, 1, 1, 0, SEC_APP), 1, 1'b1);
    wr(6'h20, 32'h0);
    lk(6'h03);
    cpu_chk(mk(0, 1, 1, 0, SEC_APP), 1, 1'b0);
    cpu_chk(mk(0, 1, 1, 0, SEC_TABLE), 1, 1'b0);
    cpu_chk(mk(0, 0, 0, 1, SEC_APP), 0, 1'b1);
    cpu_chk(mk(0, 0, 0, 0, SEC_APP), 0, 1'b0);
    cpu_chk(mk(0, 0, 1, 1, SEC_BOOT), 0, 1'b0);
    chk(32'(ext_ans), 32'h7F);
  endtask

  task automatic t_ext_lock();
    prog_model_inst.pulse(1'b1, 1'b0, 6'h00);
    lk(6'h3F);
    prog_model_inst.prog_fields(4'hF, 2'h2);
    lk(6'h3E);
    chk(32'(ext_ans), 32'h0B);
    cpu_chk(mk(1, 0, 0, 0, SEC_APP), 2, 1'b1);
    cpu_chk(mk(1, 0, 0, 0, SEC_TABLE), 2, 1'b1);
    prog_model_inst.pulse(1'b0, 1'b1, 6'h3C);
    lk(6'h3C);
    chk(32'(ext_ans), 32'h00);
    // a fully locked field must refuse even a further tightening
    prog_model_inst.pulse(1'b0, 1'b1, 6'h00);
    lk(6'h3C);
    // clock enable low: an erase must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    prog_model_inst.pulse(1'b1, 1'b0, 6'h00);
    lk(6'h3C);
    @(posedge sys_clk);
    ce <= 1'b1;
    cpu_chk(mk(0, 1, 1, 0, SEC_APP), 1, 1'b1);
    prog_model_inst.pulse(1'b1, 1'b0, 6'h00);
    lk(6'h3F);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    #400000;
    errors++;
    wrap_up();
  end

  initial begin
    errors        = 0;
    total_checks  = 0;
    rst           = 1'b1;
    ce            = 1'b1;
    cpu           = '0;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
    t_reset();
    t_calib();
    t_soft_lock();
    t_ext_lock();
    wrap_up();
  end
endmodule

`default_nettype wire
